// ===== rtl/mec_regs.sv
// Motion event configuration registers with Avalon-MM slave.
`timescale 1ns/1ns
module mec_regs #(
  parameter int TS_COARSE_CYCLES = mec_pkg::TS_COARSE_CYC,
  parameter int BIAS_SHIFT_FINE = 0,
  parameter int BIAS_SHIFT_COARSE = 2
) (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic [mec_pkg::ADDR_W-1:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  input wire logic [3:0] byteenable,
  output logic [31:0] readdata,
  output logic waitrequest,
  input wire logic [mec_pkg::NUM_EVENTS-1:0] event_in,
  input wire logic [15:0] mag_x,
  input wire logic [15:0] mag_y,
  input wire logic [15:0] mag_z,
  input wire logic sync_err_load,
  input wire logic [7:0] sync_err_value,
  input wire logic bias_weight_sel,
  input wire logic signed [15:0] accel_x,
  input wire logic signed [15:0] accel_y,
  input wire logic signed [15:0] accel_z,
  output logic signed [15:0] accel_x_corr,
  output logic signed [15:0] accel_y_corr,
  output logic signed [15:0] accel_z_corr,
  output logic four_d_select,
  output logic [6:0] orientation_angle_deg,
  output logic [4:0] tap_level,
  output logic [8:0] double_tap_window,
  output logic [3:0] quiet_periods,
  output logic [4:0] shock_periods,
  output logic double_tap_enable,
  output logic [5:0] wakeup_level,
  output logic [5:0] freefall_time,
  output logic [1:0] wakeup_time,
  output logic timestamp_fine_res,
  output logic timestamp_tick,
  output logic [12:0] sleep_entry_time,
  output logic [8:0] freefall_level,
  output logic [7:0] sync_command_code,
  output logic first_irq_pin,
  output logic second_irq_pin
);
  logic [7:0] orientation_tap_threshold;
  logic [7:0] tap_timing;
  logic [7:0] wakeup_threshold;
  logic [7:0] wakeup_sleep_duration;
  logic [7:0] freefall_config;
  logic [7:0] pin1_event_routing;
  logic [7:0] pin2_event_routing;
  logic [7:0] sync_error_code;
  logic [7:0] accel_x_user_offset;
  logic [7:0] accel_y_user_offset;
  logic [7:0] accel_z_user_offset;
  logic [7:0] irq_control;
  logic [mec_pkg::NUM_EVENTS-1:0] event_latched;
  mec_pkg::mec_bus_e bus_state;
  logic [19:0] ts_count;

  // The bus answers one cycle after the request appears.
  wire req = read | write;
  wire take = req & (bus_state == mec_pkg::MEC_ACK);
  assign waitrequest = req & (bus_state == mec_pkg::MEC_IDLE);
  wire [7:0] idx = address[mec_pkg::ADDR_W-1:2];
  wire wr_ok = take & write & byteenable[0];
  wire [7:0] wd = writedata[7:0];
  wire wr_orient = wr_ok & (idx == mec_pkg::IDX_ORIENT_TAP);
  wire wr_timing = wr_ok & (idx == mec_pkg::IDX_TAP_TIMING);
  wire wr_wake_ths = wr_ok & (idx == mec_pkg::IDX_WAKE_THS);
  wire wr_wake_sleep = wr_ok & (idx == mec_pkg::IDX_WAKE_SLEEP);
  wire wr_ff = wr_ok & (idx == mec_pkg::IDX_FREEFALL);
  wire wr_route1 = wr_ok & (idx == mec_pkg::IDX_PIN1_ROUTE);
  wire wr_route2 = wr_ok & (idx == mec_pkg::IDX_PIN2_ROUTE);
  wire wr_cmd = wr_ok & (idx == mec_pkg::IDX_SYNC_CMD);
  wire wr_err = wr_ok & (idx == mec_pkg::IDX_SYNC_ERR);
  wire wr_xb = wr_ok & (idx == mec_pkg::IDX_X_BIAS);
  wire wr_yb = wr_ok & (idx == mec_pkg::IDX_Y_BIAS);
  wire wr_zb = wr_ok & (idx == mec_pkg::IDX_Z_BIAS);
  wire wr_irq = wr_ok & (idx == mec_pkg::IDX_IRQ_CTRL);
  wire rd_status = take & read & (idx == mec_pkg::IDX_EVENT_STATUS);

  wire irq_enable = irq_control[mec_pkg::IRQ_EN_BIT];
  wire irq_latch = irq_control[mec_pkg::IRQ_LATCH_BIT];

  // Basic events pass only with the global enable; tilt, timer and the
  // iron completion belong to other engines and are not gated.
  wire [mec_pkg::NUM_EVENTS-1:0] basic_mask = 9'h1F8;
  wire dtap_gate = double_tap_enable; // RQ7
  wire [mec_pkg::NUM_EVENTS-1:0] event_gated;
  assign event_gated = event_in
    & ~(basic_mask & {mec_pkg::NUM_EVENTS{~irq_enable}}) // RQ22
    & ~({{(mec_pkg::NUM_EVENTS-mec_pkg::EV_DTAP-1){1'b0}}, ~dtap_gate,
        {mec_pkg::EV_DTAP{1'b0}}});
  wire [mec_pkg::NUM_EVENTS-1:0] event_src;
  assign event_src = irq_latch ? event_latched : event_gated; // RQ23
  wire [7:0] pin1_src = event_src[mec_pkg::NUM_EVENTS-1:1];
  wire [7:0] pin2_src = {event_src[mec_pkg::NUM_EVENTS-1:2],
                         event_src[mec_pkg::EV_IRON]};

  // A new event in the cycle of the clearing read stays latched.
  genvar g;
  generate
    for (g = 0; g < mec_pkg::NUM_EVENTS; g++) begin : g_latch
      always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
          event_latched[g] <= 1'b0;
        end else if (event_gated[g]) begin
          event_latched[g] <= 1'b1;
        end else if (rd_status) begin
          event_latched[g] <= 1'b0;
        end
      end
    end
  endgenerate

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      first_irq_pin <= 1'b0;
      second_irq_pin <= 1'b0;
    end else begin
      first_irq_pin <= |(pin1_src & pin1_event_routing); // RQ14 RQ24
      second_irq_pin <= |(pin2_src & pin2_event_routing); // RQ15 RQ24
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      bus_state <= mec_pkg::MEC_IDLE;
    end else if (bus_state == mec_pkg::MEC_IDLE && req) begin
      bus_state <= mec_pkg::MEC_ACK;
    end else begin
      bus_state <= mec_pkg::MEC_IDLE;
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      orientation_tap_threshold <= mec_pkg::REG_RESET;
      tap_timing <= mec_pkg::REG_RESET;
      wakeup_threshold <= mec_pkg::REG_RESET;
      wakeup_sleep_duration <= mec_pkg::REG_RESET;
      freefall_config <= mec_pkg::REG_RESET;
      pin1_event_routing <= mec_pkg::REG_RESET;
      pin2_event_routing <= mec_pkg::REG_RESET;
      sync_command_code <= mec_pkg::REG_RESET;
      accel_x_user_offset <= mec_pkg::REG_RESET;
      accel_y_user_offset <= mec_pkg::REG_RESET;
      accel_z_user_offset <= mec_pkg::REG_RESET;
      irq_control <= mec_pkg::REG_RESET;
    end else begin
      if (wr_orient) orientation_tap_threshold <= wd;
      if (wr_timing) tap_timing <= wd;
      if (wr_wake_ths) wakeup_threshold <= wd;
      if (wr_wake_sleep) wakeup_sleep_duration <= wd;
      if (wr_ff) freefall_config <= wd;
      if (wr_route1) pin1_event_routing <= wd;
      if (wr_route2) pin2_event_routing <= wd;
      if (wr_cmd) sync_command_code <= wd; // RQ16
      if (wr_xb) accel_x_user_offset <= wd;
      if (wr_yb) accel_y_user_offset <= wd;
      if (wr_zb) accel_z_user_offset <= wd;
      if (wr_irq) irq_control <= wd;
    end
  end

  // The sync engine's own report wins over a software write.
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      sync_error_code <= mec_pkg::REG_RESET;
    end else if (sync_err_load) begin
      sync_error_code <= sync_err_value; // RQ17
    end else if (wr_err) begin
      sync_error_code <= wd;
    end
  end

  wire [7:0] rd_byte =
    (idx == mec_pkg::IDX_ORIENT_TAP) ? orientation_tap_threshold :
    (idx == mec_pkg::IDX_TAP_TIMING) ? tap_timing :
    (idx == mec_pkg::IDX_WAKE_THS) ? wakeup_threshold :
    (idx == mec_pkg::IDX_WAKE_SLEEP) ? wakeup_sleep_duration :
    (idx == mec_pkg::IDX_FREEFALL) ? freefall_config :
    (idx == mec_pkg::IDX_PIN1_ROUTE) ? pin1_event_routing :
    (idx == mec_pkg::IDX_PIN2_ROUTE) ? pin2_event_routing :
    (idx == mec_pkg::IDX_SYNC_CMD) ? sync_command_code :
    (idx == mec_pkg::IDX_SYNC_ERR) ? sync_error_code :
    (idx == mec_pkg::IDX_MAG_XL) ? mag_x[7:0] : // RQ18
    (idx == mec_pkg::IDX_MAG_XH) ? mag_x[15:8] :
    (idx == mec_pkg::IDX_MAG_YL) ? mag_y[7:0] :
    (idx == mec_pkg::IDX_MAG_YH) ? mag_y[15:8] :
    (idx == mec_pkg::IDX_MAG_ZL) ? mag_z[7:0] :
    (idx == mec_pkg::IDX_MAG_ZH) ? mag_z[15:8] :
    (idx == mec_pkg::IDX_X_BIAS) ? accel_x_user_offset :
    (idx == mec_pkg::IDX_Y_BIAS) ? accel_y_user_offset :
    (idx == mec_pkg::IDX_Z_BIAS) ? accel_z_user_offset :
    (idx == mec_pkg::IDX_IRQ_CTRL) ? irq_control :
    8'h00;
  wire rd_is_status = (idx == mec_pkg::IDX_EVENT_STATUS);

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      readdata <= 32'h0000_0000;
    end else if (read && bus_state == mec_pkg::MEC_IDLE) begin
      readdata <= rd_is_status ? {23'h000000, event_latched}
                               : {24'h000000, rd_byte};
    end
  end

  // Field decode into physical settings, times in sample periods.
  wire [1:0] angle_sel = orientation_tap_threshold[6:5];
  wire [3:0] gap_code = tap_timing[7:4];
  wire [1:0] quiet_code = tap_timing[3:2];
  wire [1:0] shock_code = tap_timing[1:0];
  wire [3:0] sleep_code = wakeup_sleep_duration[3:0];
  wire [8:0] gap_val = (gap_code == 4'h0) ? 9'(mec_pkg::GAP_ZERO)
    : 9'(gap_code * mec_pkg::GAP_STEP);
  wire [3:0] quiet_val = (quiet_code == 2'h0) ? 4'(mec_pkg::QUIET_ZERO)
    : 4'(quiet_code * mec_pkg::QUIET_STEP);
  wire [4:0] shock_val = (shock_code == 2'h0) ? 5'(mec_pkg::SHOCK_ZERO)
    : 5'(shock_code * mec_pkg::SHOCK_STEP);
  wire [12:0] sleep_val = (sleep_code == 4'h0) ? 13'(mec_pkg::SLEEP_ZERO)
    : 13'(sleep_code * mec_pkg::SLEEP_STEP);
  wire [6:0] angle_val = 7'(mec_pkg::ANGLE_BASE_DEG
    - angle_sel * mec_pkg::ANGLE_STEP_DEG);

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      four_d_select <= 1'b0;
      orientation_angle_deg <= 7'(mec_pkg::ANGLE_BASE_DEG);
      tap_level <= 5'h00;
      double_tap_window <= 9'(mec_pkg::GAP_ZERO);
      quiet_periods <= 4'(mec_pkg::QUIET_ZERO);
      shock_periods <= 5'(mec_pkg::SHOCK_ZERO);
      double_tap_enable <= 1'b0;
      wakeup_level <= 6'h00;
      freefall_time <= 6'h00;
      wakeup_time <= 2'h0;
      timestamp_fine_res <= 1'b0;
      sleep_entry_time <= 13'(mec_pkg::SLEEP_ZERO);
      freefall_level <= mec_pkg::FF_MG_TABLE[0];
    end else begin
      four_d_select <= orientation_tap_threshold[mec_pkg::FOUR_D_BIT]; // RQ1
      orientation_angle_deg <= angle_val; // RQ2
      tap_level <= orientation_tap_threshold[4:0]; // RQ3
      double_tap_window <= gap_val; // RQ4
      quiet_periods <= quiet_val; // RQ5
      shock_periods <= shock_val; // RQ6
      double_tap_enable <= wakeup_threshold[mec_pkg::DTAP_EN_BIT]; // RQ7
      wakeup_level <= wakeup_threshold[5:0]; // RQ8
      freefall_time <= {wakeup_sleep_duration[mec_pkg::FF_HI_BIT],
                        freefall_config[7:3]}; // RQ9
      wakeup_time <= wakeup_sleep_duration[6:5]; // RQ10
      timestamp_fine_res <= wakeup_sleep_duration[mec_pkg::TS_RES_BIT];
      sleep_entry_time <= sleep_val; // RQ12
      freefall_level <= mec_pkg::FF_MG_TABLE[freefall_config[2:0]]; // RQ13
    end
  end

  // Timestamp tick, one pulse per timestamp LSB at the chosen resolution.
  // A change of resolution restarts the count so no stale tick escapes.
  logic ts_res_q;
  wire [19:0] ts_last = ts_res_q ? 20'(mec_pkg::TS_FINE_CYC - 1)
                                 : 20'(TS_COARSE_CYCLES - 1);
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      ts_res_q <= 1'b0;
      ts_count <= 20'h00000;
      timestamp_tick <= 1'b0;
    end else begin
      ts_res_q <= timestamp_fine_res;
      if (ts_res_q != timestamp_fine_res || ts_count >= ts_last) begin
        ts_count <= 20'h00000; // RQ11
      end else begin
        ts_count <= ts_count + 20'h00001;
      end
      timestamp_tick <= (ts_res_q == timestamp_fine_res)
                        && (ts_count >= ts_last);
    end
  end

  // User bias: X and Y are added, Z is subtracted; sums wrap at 16 bits.
  wire [3:0] bias_shift = bias_weight_sel ? 4'(BIAS_SHIFT_COARSE)
                                          : 4'(BIAS_SHIFT_FINE); // RQ21
  wire signed [15:0] x_bias = 16'(signed'(accel_x_user_offset)) <<< bias_shift;
  wire signed [15:0] y_bias = 16'(signed'(accel_y_user_offset)) <<< bias_shift;
  wire signed [15:0] z_bias = 16'(signed'(accel_z_user_offset)) <<< bias_shift;

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      accel_x_corr <= 16'sh0000;
      accel_y_corr <= 16'sh0000;
      accel_z_corr <= 16'sh0000;
    end else begin
      accel_x_corr <= accel_x + x_bias; // RQ19
      accel_y_corr <= accel_y + y_bias; // RQ19
      accel_z_corr <= accel_z - z_bias; // RQ20
    end
  end
endmodule

// ===== rtl/mec_pkg.sv
// Constants, register map and field layout of the motion event registers.
// Overview of operation
// RQ1: Orientation mode bit selects 4D, ignoring Z.
// RQ2: Angle field picks 80, 70, 60, 50 degrees.
// RQ3: Tap level LSB is full scale over 32.
// RQ4: Double-tap gap: zero 16, else 32 periods each.
// RQ5: Quiet after tap: zero 2, else 4 each.
// RQ6: Shock limit: zero 4, else 8 periods each.
// RQ7: Select bit enables double-tap besides single-tap.
// RQ8: Wakeup level LSB is full scale over 64.
// RQ9: Six-bit free-fall time split over two registers.
// RQ10: Two-bit wakeup time in sample periods.
// RQ11: Timestamp LSB is 6.4 ms or 25 us.
// RQ12: Sleep entry: zero 16, else 512 each.
// RQ13: Free-fall level maps onto 156 to 500 mg.
// RQ14: Eight routing bits gate events onto pin one.
// RQ15: Eight routing bits gate events onto pin two.
// RQ16: Host loads eight-bit sync command code.
// RQ17: Eight-bit sync error code register, reset zero.
// RQ18: Read-only 16-bit magnetometer data, low byte first.
// RQ19: Signed X and Y offsets added to acceleration.
// RQ20: Signed Z offset subtracted from acceleration.
// RQ21: External control bit sets offset LSB weight.
// RQ22: Global enable gates the basic interrupts.
// RQ23: Latch bit picks pulsed or latched requests.
// RQ24: Each pin is OR of routed events.
package mec_pkg;
  localparam int ADDR_W = 10;
  localparam logic [7:0] IDX_ORIENT_TAP = 8'h59;
  localparam logic [7:0] IDX_TAP_TIMING = 8'h5A;
  localparam logic [7:0] IDX_WAKE_THS = 8'h5B;
  localparam logic [7:0] IDX_WAKE_SLEEP = 8'h5C;
  localparam logic [7:0] IDX_FREEFALL = 8'h5D;
  localparam logic [7:0] IDX_PIN1_ROUTE = 8'h5E;
  localparam logic [7:0] IDX_PIN2_ROUTE = 8'h5F;
  localparam logic [7:0] IDX_SYNC_CMD = 8'h60;
  localparam logic [7:0] IDX_SYNC_ERR = 8'h61;
  localparam logic [7:0] IDX_MAG_XL = 8'h66;
  localparam logic [7:0] IDX_MAG_XH = 8'h67;
  localparam logic [7:0] IDX_MAG_YL = 8'h68;
  localparam logic [7:0] IDX_MAG_YH = 8'h69;
  localparam logic [7:0] IDX_MAG_ZL = 8'h6A;
  localparam logic [7:0] IDX_MAG_ZH = 8'h6B;
  localparam logic [7:0] IDX_X_BIAS = 8'h73;
  localparam logic [7:0] IDX_Y_BIAS = 8'h74;
  localparam logic [7:0] IDX_Z_BIAS = 8'h75;
  localparam logic [7:0] IDX_IRQ_CTRL = 8'h58;
  localparam logic [7:0] IDX_EVENT_STATUS = 8'h62;
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam int IRQ_EN_BIT = 7;
  localparam int IRQ_LATCH_BIT = 0;
  localparam int FOUR_D_BIT = 7;
  localparam int DTAP_EN_BIT = 7;
  localparam int FF_HI_BIT = 7;
  localparam int TS_RES_BIT = 4;
  localparam int ANGLE_BASE_DEG = 80;
  localparam int ANGLE_STEP_DEG = 10;
  localparam int GAP_ZERO = 16;
  localparam int GAP_STEP = 32;
  localparam int QUIET_ZERO = 2;
  localparam int QUIET_STEP = 4;
  localparam int SHOCK_ZERO = 4;
  localparam int SHOCK_STEP = 8;
  localparam int SLEEP_ZERO = 16;
  localparam int SLEEP_STEP = 512;
  localparam int TAP_LEVEL_SHIFT = 5;
  localparam int WAKE_LEVEL_SHIFT = 6;
  localparam logic [8:0] FF_MG_TABLE [8] =
    '{9'd156, 9'd219, 9'd250, 9'd312, 9'd344, 9'd406, 9'd469, 9'd500};
  localparam int CLK_PERIOD_NS = 8;
  localparam int TS_COARSE_NS = 6400000;
  localparam int TS_FINE_NS = 25000;
  localparam int TS_COARSE_CYC = TS_COARSE_NS / CLK_PERIOD_NS;
  localparam int TS_FINE_CYC = TS_FINE_NS / CLK_PERIOD_NS;
  localparam int NUM_EVENTS = 9;
  // Event bit order in the status register and the event input vector.
  localparam int EV_INACT = 8;
  localparam int EV_STAP = 7;
  localparam int EV_WAKE = 6;
  localparam int EV_FF = 5;
  localparam int EV_DTAP = 4;
  localparam int EV_6D = 3;
  localparam int EV_TILT = 2;
  localparam int EV_TIMER = 1;
  localparam int EV_IRON = 0;
  typedef enum logic [0:0] {
    MEC_IDLE = 1'b0,
    MEC_ACK = 1'b1
  } mec_bus_e;
endpackage

// ===== tb/mec_sensor_model.sv
// Sensor-side model driving events, raw data, samples and sync errors.
`timescale 1ns/1ns
module mec_sensor_model #(
  parameter logic [15:0] MX = 16'h1234,
  parameter logic [15:0] MY = 16'h5678,
  parameter logic [15:0] MZ = 16'h9ABC
) (
  input wire logic ref_clk,
  input wire logic [8:0] ev_req,
  input wire logic err_go,
  output logic [8:0] event_in,
  output logic [15:0] mag_x,
  output logic [15:0] mag_y,
  output logic [15:0] mag_z,
  output logic sync_err_load,
  output logic [7:0] sync_err_value,
  output logic signed [15:0] accel_x,
  output logic signed [15:0] accel_y,
  output logic signed [15:0] accel_z
);
  logic [8:0] ev_q = 9'h000;
  logic ld_q = 1'b0;
  logic [7:0] val_q = 8'hA1;
  assign mag_x = MX;
  assign mag_y = MY;
  assign mag_z = MZ;
  assign accel_x = 16'sh0064;
  assign accel_y = 16'sh0064;
  assign accel_z = 16'sh0064;
  assign event_in = ev_q;
  assign sync_err_load = ld_q;
  assign sync_err_value = val_q;
  // The value bus shows a decoy outside the load pulse on purpose.
  always_ff @(posedge ref_clk) begin
    ev_q <= ev_req;
    ld_q <= err_go;
    val_q <= err_go ? 8'h5E : 8'hA1;
  end
endmodule

// ===== tb/mec_regs_checker.sv
// Concurrent checks on the motion event register bank ports.
`timescale 1ns/1ns
module mec_regs_checker (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic read,
  input wire logic write,
  input wire logic waitrequest,
  input wire logic [6:0] orientation_angle_deg,
  input wire logic [8:0] double_tap_window,
  input wire logic [3:0] quiet_periods,
  input wire logic [4:0] shock_periods,
  input wire logic [12:0] sleep_entry_time,
  input wire logic [8:0] freefall_level,
  input wire logic timestamp_tick
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!nrst);
  sequence s_one_wait;
    waitrequest ##1 !waitrequest;
  endsequence
  a_bus_one_wait: assert property (($rose(read) || $rose(write)) |-> s_one_wait)
    else $error("bus answer not after exactly one wait");
  a_angle_legal: assert property (orientation_angle_deg inside
    {7'd80, 7'd70, 7'd60, 7'd50}) else $error("angle threshold illegal");
  a_gap_legal: assert property ((double_tap_window == 9'd16) ||
    (double_tap_window[4:0] == 5'd0 && double_tap_window != 9'd0))
    else $error("double tap window illegal");
  a_quiet_legal: assert property (quiet_periods inside
    {4'd2, 4'd4, 4'd8, 4'd12}) else $error("quiet time illegal");
  a_shock_legal: assert property (shock_periods inside
    {5'd4, 5'd8, 5'd16, 5'd24}) else $error("shock time illegal");
  a_sleep_legal: assert property ((sleep_entry_time == 13'd16) ||
    (sleep_entry_time[8:0] == 9'd0 && sleep_entry_time != 13'd0))
    else $error("sleep entry time illegal");
  a_fflevel_legal: assert property (freefall_level inside {9'd156,
    9'd219, 9'd250, 9'd312, 9'd344, 9'd406, 9'd469, 9'd500})
    else $error("free-fall level illegal");
  a_tick_spacing: assert property (timestamp_tick |=>
    (!timestamp_tick) [*8]) else $error("timestamp ticks too close");
endmodule
bind mec_regs mec_regs_checker i_mec_regs_checker (.ref_clk, .nrst, .read,
  .write, .waitrequest, .orientation_angle_deg, .double_tap_window,
  .quiet_periods, .shock_periods, .sleep_entry_time, .freefall_level,
  .timestamp_tick);

// ===== tb/tb_top.sv
// Self-checking bench for the motion event register bank.
`timescale 1ns/1ns
module tb_top;
  localparam int TS = 50;
  localparam logic [15:0] MX = 16'h1234;
  localparam logic [15:0] MY = 16'h5678;
  localparam logic [15:0] MZ = 16'h9ABC;
  localparam logic [7:0] RW_IDX [12] = '{8'h59, 8'h5A, 8'h5B, 8'h5C, 8'h5D,
    8'h5E, 8'h5F, 8'h60, 8'h61, 8'h73, 8'h74, 8'h75};
  localparam int FF_MG [8] = '{156, 219, 250, 312, 344, 406, 469, 500};
  localparam logic [7:0] TIM [3] = '{8'h00, 8'hFF, 8'h96};
  localparam logic [7:0] WSD_VALS [2] = '{8'hB5, 8'h4A};
  logic ref_clk, nrst, read, write, waitrequest, bias_weight_sel, err_go;
  logic [9:0] address;
  logic [31:0] writedata, readdata, rd_x;
  logic [3:0] byteenable, quiet_periods;
  logic [8:0] event_in, ev_req, double_tap_window, freefall_level;
  logic [15:0] mag_x, mag_y, mag_z;
  logic sync_err_load, four_d_select, double_tap_enable, timestamp_fine_res;
  logic [7:0] sync_err_value, sync_command_code, v;
  logic signed [15:0] accel_x, accel_y, accel_z;
  logic signed [15:0] accel_x_corr, accel_y_corr, accel_z_corr;
  logic timestamp_tick, first_irq_pin, second_irq_pin;
  logic [6:0] orientation_angle_deg;
  logic [4:0] tap_level, shock_periods;
  logic [5:0] wakeup_level, freefall_time;
  logic [1:0] wakeup_time;
  logic [12:0] sleep_entry_time;
  int n_mismatch = 0;
  int num_checks = 0;
  mec_regs #(.TS_COARSE_CYCLES(TS)) i_mec_regs (.ref_clk, .nrst, .address,
    .read, .write, .writedata, .byteenable, .readdata, .waitrequest,
    .event_in, .mag_x, .mag_y, .mag_z, .sync_err_load, .sync_err_value,
    .bias_weight_sel, .accel_x, .accel_y, .accel_z, .accel_x_corr,
    .accel_y_corr, .accel_z_corr, .four_d_select, .orientation_angle_deg,
    .tap_level, .double_tap_window, .quiet_periods, .shock_periods,
    .double_tap_enable, .wakeup_level, .freefall_time, .wakeup_time,
    .timestamp_fine_res, .timestamp_tick, .sleep_entry_time,
    .freefall_level, .sync_command_code, .first_irq_pin, .second_irq_pin);
  mec_sensor_model #(.MX(MX), .MY(MY), .MZ(MZ)) i_mec_sensor_model (
    .ref_clk, .ev_req, .err_go, .event_in, .mag_x, .mag_y, .mag_z,
    .sync_err_load, .sync_err_value, .accel_x, .accel_y, .accel_z);
  task automatic summarize();
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask
  // The request is held until the edge that sees waitrequest low.
  task automatic bus(input logic [7:0] idx, input logic wr,
    input logic [7:0] wd, input logic [3:0] be, output logic [31:0] rd);
    int k;
    k = 0;
    @(posedge ref_clk);
    address <= {idx, 2'b00};
    read <= !wr;
    write <= wr;
    writedata <= {24'h000000, wd};
    byteenable <= be;
    do begin
      @(posedge ref_clk);
      k++;
    end while (waitrequest !== 1'b0 && k < 20);
    rd = readdata;
    read <= 1'b0;
    write <= 1'b0;
    if (waitrequest !== 1'b0) begin
      n_mismatch++;
      summarize();
    end
  endtask
  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    bus(idx, 1'b1, d, 4'hF, rd_x);
  endtask
  task automatic rdc(input logic [7:0] idx, input logic [31:0] exp);
    bus(idx, 1'b0, 8'h00, 4'hF, rd_x);
    chk(rd_x, exp);
  endtask
  task automatic settle();
    repeat (3) @(negedge ref_clk);
  endtask
  task automatic pulse(input logic [8:0] m, input logic e1, input logic e2);
    @(posedge ref_clk);
    ev_req <= m;
    @(posedge ref_clk);
    ev_req <= 9'h000;
    @(posedge ref_clk);
    @(negedge ref_clk);
    chk({31'h0, first_irq_pin}, {31'h0, e1});
    chk({31'h0, second_irq_pin}, {31'h0, e2});
  endtask
  task automatic tick_gap(input int exp);
    int n;
    n = 0;
    while (timestamp_tick !== 1'b1 && n < 4000) begin
      @(negedge ref_clk);
      n++;
    end
    n = 0;
    do begin
      @(negedge ref_clk);
      n++;
    end while (timestamp_tick !== 1'b1 && n < 4000);
    chk(32'(n), 32'(exp));
    // A tick that never comes ends the run instead of skewing later checks.
    if (timestamp_tick !== 1'b1) begin
      n_mismatch++;
      summarize();
    end
  endtask
  initial begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end
  initial begin
    nrst = 1'b0;
    read = 1'b0;
    write = 1'b0;
    address = 10'h000;
    writedata = 32'h00000000;
    byteenable = 4'hF;
    ev_req = 9'h000;
    err_go = 1'b0;
    bias_weight_sel = 1'b0;
    repeat (6) @(posedge ref_clk);
    nrst <= 1'b1;
    foreach (RW_IDX[i]) rdc(RW_IDX[i], 32'h0);
    rdc(8'h70, 32'h0);
    foreach (RW_IDX[i]) begin
      wr(RW_IDX[i], 8'hA5 ^ 8'(i));
      rdc(RW_IDX[i], {24'h0, 8'hA5 ^ 8'(i)});
    end
    for (int c = 0; c < 4; c++) begin
      wr(8'h59, {1'(c), 2'(c), 5'h13});
      settle();
      chk(32'(orientation_angle_deg), 32'(80 - 10 * c));
      chk({31'h0, four_d_select}, 32'(c % 2));
      chk(32'(tap_level), 32'h13);
    end
    foreach (TIM[i]) begin
      v = TIM[i];
      wr(8'h5A, v);
      settle();
      chk(32'(double_tap_window), v[7:4] == 0 ? 16 : 32 * v[7:4]);
      chk(32'(quiet_periods), v[3:2] == 0 ? 2 : 4 * v[3:2]);
      chk(32'(shock_periods), v[1:0] == 0 ? 4 : 8 * v[1:0]);
    end
    wr(8'h5B, 8'hBF);
    settle();
    chk({31'h0, double_tap_enable}, 32'h1);
    chk(32'(wakeup_level), 32'h3F);
    wr(8'h5D, 8'h5B);
    foreach (WSD_VALS[i]) begin
      v = WSD_VALS[i];
      wr(8'h5C, v);
      settle();
      chk(32'(freefall_time), {26'h0, v[7], 5'h0B});
      chk(32'(wakeup_time), 32'(v[6:5]));
      chk({31'h0, timestamp_fine_res}, 32'(v[4]));
      chk(32'(sleep_entry_time), v[3:0] == 0 ? 16 : 512 * v[3:0]);
    end
    tick_gap(TS);
    wr(8'h5C, 8'h10);
    tick_gap(3125);
    for (int c = 0; c < 8; c++) begin
      wr(8'h5D, {5'h0B, 3'(c)});
      settle();
      chk(32'(freefall_level), 32'(FF_MG[c]));
    end
    wr(8'h60, 8'hC3);
    settle();
    chk(32'(sync_command_code), 32'hC3);
    bus(8'h60, 1'b1, 8'h11, 4'hE, rd_x);
    rdc(8'h60, 32'hC3);
    @(posedge ref_clk);
    err_go <= 1'b1;
    @(posedge ref_clk);
    err_go <= 1'b0;
    rdc(8'h61, 32'h5E);
    rdc(8'h66, {24'h0, MX[7:0]});
    rdc(8'h67, {24'h0, MX[15:8]});
    rdc(8'h68, {24'h0, MY[7:0]});
    rdc(8'h69, {24'h0, MY[15:8]});
    rdc(8'h6A, {24'h0, MZ[7:0]});
    rdc(8'h6B, {24'h0, MZ[15:8]});
    wr(8'h66, 8'hFF);
    rdc(8'h66, {24'h0, MX[7:0]});
    wr(8'h73, 8'h7F);
    wr(8'h74, 8'h81);
    wr(8'h75, 8'h10);
    settle();
    chk({16'h0, accel_x_corr}, {16'h0, 16'(100 + 127)});
    chk({16'h0, accel_y_corr}, {16'h0, 16'(100 - 127)});
    chk({16'h0, accel_z_corr}, {16'h0, 16'(100 - 16)});
    @(posedge ref_clk);
    bias_weight_sel <= 1'b1;
    settle();
    chk({16'h0, accel_x_corr}, {16'h0, 16'(100 + 508)});
    chk({16'h0, accel_z_corr}, {16'h0, 16'(100 - 64)});
    wr(8'h58, 8'h80);
    wr(8'h5E, 8'h10);
    wr(8'h5F, 8'h02);
    pulse(9'h020, 1'b1, 1'b0);
    pulse(9'h004, 1'b0, 1'b1);
    wr(8'h58, 8'h00);
    pulse(9'h020, 1'b0, 1'b0);
    pulse(9'h004, 1'b0, 1'b1);
    bus(8'h62, 1'b0, 8'h00, 4'hF, rd_x);
    wr(8'h58, 8'h81);
    pulse(9'h020, 1'b0, 1'b0);
    settle();
    chk({31'h0, first_irq_pin}, 32'h1);
    rdc(8'h62, 32'h020);
    settle();
    chk({31'h0, first_irq_pin}, 32'h0);
    wr(8'h58, 8'h80);
    wr(8'h5E, 8'h08);
    wr(8'h5B, 8'h00);
    pulse(9'h010, 1'b0, 1'b0);
    wr(8'h5B, 8'h80);
    pulse(9'h010, 1'b1, 1'b0);
    summarize();
  end
endmodule
